// File: flash_array_model.sv
// Far-side model: code array bytes fed to the table read path
`timescale 1ns/1ps
module flash_array_model
  import flash_guard_pkg::*;
(
  input  wire logic                      table_read,
  input  wire logic [CODE_ADDR_BITS-1:0] table_addr,
  output logic      [7:0]                table_raw
);
  // ==========================================================================
  // Array contents
  // ==========================================================================
  // Content hashed from the address; inverted when idle so stale data never looks valid
  assign table_raw = table_read ? (table_addr[7:0] ^ table_addr[15:8])
                                : ~(table_addr[7:0] ^ table_addr[15:8]);
endmodule // flash_array_model

// File: flash_guard_pkg.sv
// Package: constants, types and offsets for the flash sector guard block
package flash_guard_pkg;

  // ==========================================================================
  // Geometry and register map
  // ==========================================================================
  localparam int unsigned NUM_SECTORS       = 8;
  localparam int unsigned SECTOR_ADDR_BITS  = 11;
  localparam int unsigned CODE_ADDR_BITS    = 16;
  localparam logic [7:0]  OFFS_SECTOR_BASE  = 8'h00;  // 8 consecutive words
  localparam logic [7:0]  OFFS_BOOT_VECTOR  = 8'h08;
  localparam logic [7:0]  OFFS_BOOT_STATUS  = 8'h09;
  localparam logic [7:0]  OFFS_OSC_CONFIG   = 8'h0a;
  localparam logic [7:0]  OFFS_IRQ_STATUS   = 8'h0b;
  localparam logic [7:0]  OFFS_IRQ_MASK     = 8'h0c;
  localparam logic [7:0]  OFFS_FLASH_STATE  = 8'h0d;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned BIT_TABLE_READ_DIS = 0;
  localparam int unsigned BIT_PROG_ERASE_DIS = 1;
  localparam int unsigned BIT_ERASE_DIS      = 2;
  localparam int unsigned BIT_BOOT_STATUS    = 0;
  localparam int unsigned BIT_ACT_WRITE_PROT = 5;
  localparam int unsigned BIT_CFG_WRITE_PROT = 6;
  localparam int unsigned BIT_DIS_CLEAR_PROT = 7;
  localparam int unsigned IRQ_VIOLATION      = 0;
  localparam int unsigned IRQ_DONE           = 1;

  // ==========================================================================
  // Reset and factory values, field masks, key
  // ==========================================================================
  localparam logic [7:0] SECTOR_RESET      = 8'h00;
  localparam logic [7:0] SECTOR_FIELD_MASK = 8'h07;
  localparam logic [7:0] BOOT_VECTOR_RESET = 8'h1f;
  localparam logic [7:0] BOOT_VECTOR_MASK  = 8'h1f;
  localparam logic [7:0] BOOT_STATUS_RESET = 8'h01;
  localparam logic [7:0] BOOT_STATUS_MASK  = 8'he1;
  localparam logic [7:0] OSC_CONFIG_RESET  = 8'h63;
  localparam logic [7:0] CLEAR_PROT_KEY    = 8'h96;
  localparam logic [7:0] INVALID_DATA      = 8'hff;
  localparam logic [7:0] RESET_ADDR_LOW    = 8'h00;

  // ==========================================================================
  // Commands and programming sources
  // ==========================================================================
  typedef enum logic [3:0] {
    CMD_NONE, CMD_PROGRAM, CMD_ERASE_PAGE, CMD_ERASE_SECTOR, CMD_ERASE_GLOBAL,
    CMD_SECTOR_CRC, CMD_GLOBAL_CRC, CMD_SET_WRITE_ENABLE, CMD_CLEAR_WRITE_ENABLE,
    CMD_CLEAR_CONFIG_PROT, CMD_WRITE_CONFIG
  } flash_cmd_t;

  typedef enum logic [1:0] {
    SRC_IN_APPLICATION, SRC_IN_SYSTEM, SRC_IN_CIRCUIT, SRC_PARALLEL
  } prog_source_t;

  // Command request from the sequencer
  typedef struct packed {
    flash_cmd_t                  cmd;
    prog_source_t                source;
    logic [CODE_ADDR_BITS-1:0]   addr;
    logic [7:0]                  data;
  } flash_req_t;

  // Verdict returned to the sequencer
  typedef struct packed {
    logic done;
    logic violation;
    logic array_write;
    logic array_erase;
  } flash_rsp_t;

endpackage : flash_guard_pkg

// File: flash_sector_guard.sv
// Sector protection, boot configuration and command gate for the code flash
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
// How it works
// RULE1 - Eight security bytes, flags in bits 2:0, upper bits reserved, unprogrammed 0.
// RULE2 - Table read from a sector with read-disable set returns invalid data.
// RULE3 - Read-disable flag clears only when its own sector is erased.
// RULE4 - Program-erase-disable blocks writes; sector or programmer global erase clears it.
// RULE5 - Erase-disable refuses in-system/in-application erase; only programmer global erase clears. Here a programmer sector erase also clears it.
// RULE6 - Sector checksum violates when read-disable set and both other flags clear.
// RULE7 - Global checksum violates when any sector has read-disable set.
// RULE8 - Read-disable alone never makes program or erase commands violate.
// RULE9 - Program-erase-disable: program and page erase violate; sector/global erase proceed.
// RULE10 - Erase-disable: program and page erase violate; only global erase proceeds. Here a sector erase from circuit or parallel also proceeds.
// RULE11 - Boot address is boot vector field as high byte, low byte 00h.
// RULE12 - Boot status bit set means every reset starts at the boot address.
// RULE13 - Write-protection inactive forces write enable; active, only commands change it.
// RULE14 - Configuration write protect blocks writes to the three configuration bytes.
// RULE15 - Host clears protection by command then key 96h on the data register.
// RULE16 - Disable-clear-protection rejects the clear command in system or application mode.
// RULE17 - Disable-clear-protection clears only via clear command from circuit or parallel.
// RULE18 - Flags checked before any change; violation flagged in the aborting cycle.
module flash_sector_guard
  import flash_guard_pkg::*;
#(
  parameter int unsigned SECTORS = flash_guard_pkg::NUM_SECTORS
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 clk_en,
  // Register port
  input  wire logic [7:0]                           reg_addr,
  input  wire logic [7:0]                           reg_wdata,
  input  wire logic                                 reg_write,
  input  wire logic                                 reg_read,
  output logic      [7:0]                           reg_rdata,
  // Command interface
  input  wire logic                                 cmd_valid,
  input  wire flash_guard_pkg::flash_req_t          cmd_req,
  input  wire logic                                 key_write,
  input  wire logic [7:0]                           key_data,
  output flash_guard_pkg::flash_rsp_t               cmd_rsp,
  // Table read path
  input  wire logic                                 table_read,
  input  wire logic [flash_guard_pkg::CODE_ADDR_BITS-1:0] table_addr,
  input  wire logic [7:0]                           table_raw,
  output logic      [7:0]                           table_data,
  // Status toward the core
  output logic      [flash_guard_pkg::CODE_ADDR_BITS-1:0] boot_address,
  output logic                                      boot_select,
  output logic                                      write_enable,
  output logic      [7:0]                           osc_config,
  output logic                                      irq
);
  import flash_guard_pkg::*;

  // Decode and read mux are built for exactly eight sectors
  if (SECTORS != NUM_SECTORS) begin : g_bad_sectors
    $error("sector count must be eight");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  logic [7:0] sector_prot [SECTORS];
  logic [7:0] boot_vector_byte;
  logic [7:0] boot_status_byte;
  logic [7:0] osc_byte;
  logic       write_enable_flag;
  logic       clear_armed;
  logic       from_prog_armed;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  // Sector of an address: top three bits of the 16-bit code space
  function automatic logic [2:0] sector_of(input logic [CODE_ADDR_BITS-1:0] a);
    return a[CODE_ADDR_BITS-1 -: 3];
  endfunction

  // ==========================================================================
  // Command decode
  // ==========================================================================
  wire       go          = clk_en & cmd_valid;
  wire [2:0] cmd_sector  = sector_of(cmd_req.addr);
  wire [7:0] tgt         = sector_prot[cmd_sector];
  wire       tgt_rd_dis  = tgt[BIT_TABLE_READ_DIS];
  wire       tgt_pe_dis  = tgt[BIT_PROG_ERASE_DIS];
  wire       tgt_e_dis   = tgt[BIT_ERASE_DIS];
  wire       from_prog   = (cmd_req.source == SRC_IN_CIRCUIT) ||
                           (cmd_req.source == SRC_PARALLEL);
  wire       is_program  = cmd_req.cmd == CMD_PROGRAM;
  wire       is_page     = cmd_req.cmd == CMD_ERASE_PAGE;
  wire       is_sector   = cmd_req.cmd == CMD_ERASE_SECTOR;
  wire       is_global   = cmd_req.cmd == CMD_ERASE_GLOBAL;
  wire       is_clr_prot = cmd_req.cmd == CMD_CLEAR_CONFIG_PROT;
  wire       is_cfg_wr   = cmd_req.cmd == CMD_WRITE_CONFIG;
  wire       cfg_locked  = boot_status_byte[BIT_CFG_WRITE_PROT];

  // Any read-disable flag in the array
  logic any_rd_dis;
  always_comb begin
    any_rd_dis = 1'b0;
    for (int i = 0; i < SECTORS; i++) begin
      any_rd_dis = any_rd_dis | sector_prot[i][BIT_TABLE_READ_DIS];
    end
  end

  // Violation verdict, computed from stored flags before anything changes
  wire viol_write  = (is_program | is_page) & (tgt_pe_dis | tgt_e_dis);  // RULE9 RULE10 RULE8
  wire viol_sector = is_sector & tgt_e_dis & ~from_prog;                // RULE5 RULE10
  wire viol_global = is_global & ~from_prog;                            // RULE5
  wire viol_scrc   = (cmd_req.cmd == CMD_SECTOR_CRC) & tgt_rd_dis &
                     ~tgt_pe_dis & ~tgt_e_dis;                          // RULE6
  wire viol_gcrc   = (cmd_req.cmd == CMD_GLOBAL_CRC) & any_rd_dis;      // RULE7
  wire viol_cfg    = is_cfg_wr & cfg_locked;                            // RULE14
  wire viol_clr    = is_clr_prot & boot_status_byte[BIT_DIS_CLEAR_PROT] & ~from_prog; // RULE16
  wire violation   = viol_write | viol_sector | viol_global | viol_scrc |
                     viol_gcrc | viol_cfg | viol_clr;                   // RULE18
  wire ok          = go & ~violation;
  wire wr_blocked  = ~write_enable_flag;

  // Array strobes reach the array only for accepted commands
  assign cmd_rsp.done        = go;
  assign cmd_rsp.violation   = go & violation;                          // RULE18
  assign cmd_rsp.array_write = ok & is_program & ~wr_blocked;
  assign cmd_rsp.array_erase = ok & (is_page | is_sector | is_global) & ~wr_blocked;

  // ==========================================================================
  // Register decode
  // ==========================================================================
  wire       wr_go       = clk_en & reg_write;
  wire       sel_sector  = reg_addr < (OFFS_SECTOR_BASE + 8'(SECTORS));
  wire [2:0] reg_sector  = reg_addr[2:0];
  wire       wr_boot_ok  = wr_go & ~cfg_locked;                         // RULE14
  wire       wr_irq_stat = wr_go & (reg_addr == OFFS_IRQ_STATUS);
  wire       wr_irq_mask = wr_go & (reg_addr == OFFS_IRQ_MASK);
  wire       key_clr_ok  = clk_en & clear_armed & key_write &
                           (key_data == CLEAR_PROT_KEY);                // RULE15
  wire       clr_drop    = key_clr_ok & from_prog_armed;                // RULE17
  // A plain status write may set the clear-disable bit but never drop it
  wire [7:0] clr_dis_keep = boot_status_byte & (8'h01 << BIT_DIS_CLEAR_PROT);

  // ==========================================================================
  // Sector security bytes
  // ==========================================================================
  // Programming only sets bits; clearing needs an erase
  generate
    for (genvar s = 0; s < SECTORS; s++) begin : g_sector
      wire hit_reg  = wr_go & sel_sector & (reg_sector == 3'(s));
      wire hit_sect = ok & is_sector & ~wr_blocked & (cmd_sector == 3'(s)); // RULE3 RULE4
      wire hit_glob = ok & is_global & ~wr_blocked;                     // RULE5
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          sector_prot[s] <= SECTOR_RESET;                               // RULE1
        end else if (hit_sect || hit_glob) begin
          sector_prot[s] <= SECTOR_RESET;
        end else if (hit_reg) begin
          sector_prot[s] <= sector_prot[s] | (reg_wdata & SECTOR_FIELD_MASK); // RULE1
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Boot configuration bytes
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      boot_vector_byte <= BOOT_VECTOR_RESET;
      osc_byte         <= OSC_CONFIG_RESET;
    end else if (wr_boot_ok && reg_addr == OFFS_BOOT_VECTOR) begin
      boot_vector_byte <= reg_wdata & BOOT_VECTOR_MASK;                 // RULE14
    end else if (wr_boot_ok && reg_addr == OFFS_OSC_CONFIG) begin
      osc_byte         <= reg_wdata;                                    // RULE14
    end
  end

  // Key clear wins over programming; the protect bits only set by programming
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      boot_status_byte <= BOOT_STATUS_RESET;
    end else if (key_clr_ok) begin
      boot_status_byte[BIT_CFG_WRITE_PROT] <= 1'b0;                     // RULE15
      if (from_prog_armed) begin
        boot_status_byte[BIT_DIS_CLEAR_PROT] <= 1'b0;                   // RULE17
      end
    end else if (wr_boot_ok && reg_addr == OFFS_BOOT_STATUS) begin
      boot_status_byte <= (reg_wdata & BOOT_STATUS_MASK) | clr_dis_keep; // RULE17
    end
  end

  // ==========================================================================
  // Clear-protection arming and write enable
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clear_armed     <= 1'b0;
      from_prog_armed <= 1'b0;
    end else if (clk_en) begin
      if (ok && is_clr_prot) begin
        clear_armed     <= 1'b1;                                        // RULE16
        from_prog_armed <= from_prog;
      end else if (key_write || go) begin
        clear_armed     <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      write_enable_flag <= 1'b1;
    end else if (clk_en && !boot_status_byte[BIT_ACT_WRITE_PROT]) begin
      write_enable_flag <= 1'b1;                                        // RULE13
    end else if (ok && cmd_req.cmd == CMD_SET_WRITE_ENABLE) begin
      write_enable_flag <= 1'b1;                                        // RULE13
    end else if (ok && cmd_req.cmd == CMD_CLEAR_WRITE_ENABLE) begin
      write_enable_flag <= 1'b0;                                        // RULE13
    end
  end

  // ==========================================================================
  // Interrupts: sticky, set wins over write-one-to-clear
  // ==========================================================================
  wire [1:0] irq_events = {go, go & violation};
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~(wr_irq_stat ? reg_wdata[1:0] : 2'h0)) | irq_events;
      if (wr_irq_mask) begin
        irq_mask <= reg_wdata[1:0];
      end
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ==========================================================================
  // Table read gate and outputs
  // ==========================================================================
  wire [7:0] rd_prot = sector_prot[sector_of(table_addr)];
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      table_data <= 8'h00;
    end else if (clk_en && table_read) begin
      table_data <= rd_prot[BIT_TABLE_READ_DIS] ? INVALID_DATA : table_raw; // RULE2
    end
  end

  assign boot_address = {boot_vector_byte, RESET_ADDR_LOW};             // RULE11
  assign boot_select  = boot_status_byte[BIT_BOOT_STATUS];              // RULE12
  assign write_enable = write_enable_flag;
  assign osc_config   = osc_byte;

  // Read mux, one cycle later
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (sel_sector) next_rdata = sector_prot[reg_sector];
    else if (reg_addr == OFFS_BOOT_VECTOR) next_rdata = boot_vector_byte;
    else if (reg_addr == OFFS_BOOT_STATUS) next_rdata = boot_status_byte;
    else if (reg_addr == OFFS_OSC_CONFIG)  next_rdata = osc_byte;
    else if (reg_addr == OFFS_IRQ_STATUS)  next_rdata = {6'h00, irq_status};
    else if (reg_addr == OFFS_IRQ_MASK)    next_rdata = {6'h00, irq_mask};
    else if (reg_addr == OFFS_FLASH_STATE) next_rdata = {6'h00, clear_armed, write_enable_flag};
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_page_guard: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE9
    go && (is_page || is_program) && tgt_pe_dis |-> cmd_rsp.violation && !cmd_rsp.array_erase
    && !cmd_rsp.array_write) else $error("protected page write went through");
  a_edis_erase: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE10
    go && is_sector && tgt_e_dis && !from_prog |-> cmd_rsp.violation)
    else $error("erase-disabled sector erased in system");
  a_rd_no_viol: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE8
    go && is_program && tgt == 8'h01 |-> !cmd_rsp.violation)
    else $error("read-disable alone blocked a program");
  a_gcrc_viol: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE7
    go && cmd_req.cmd == CMD_GLOBAL_CRC && any_rd_dis |-> cmd_rsp.violation)
    else $error("global checksum not refused");
  a_scrc_viol: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE6
    go && cmd_req.cmd == CMD_SECTOR_CRC && tgt[2:0] == 3'h1 |-> cmd_rsp.violation)
    else $error("sector checksum not refused");
  a_table_gate: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE2
    clk_en && table_read && rd_prot[0] |=> table_data == INVALID_DATA)
    else $error("protected byte leaked");
  a_sector_clear: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE3
    ok && is_sector && write_enable_flag |=> sector_prot[$past(cmd_sector)] == SECTOR_RESET)
    else $error("sector erase left flags");
  a_we_forced: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE13
    clk_en && !boot_status_byte[BIT_ACT_WRITE_PROT] |=> write_enable_flag)
    else $error("write enable not forced");
  a_cfg_lock: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE14
    wr_go && cfg_locked && !key_clr_ok && reg_addr == OFFS_BOOT_STATUS
    |=> $stable(boot_status_byte)) else $error("locked config byte changed");
  a_boot_addr: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE11
    boot_address[7:0] == RESET_ADDR_LOW && boot_address[15:8] == boot_vector_byte)
    else $error("boot address malformed");
  a_clear_disabled: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE16
    go && is_clr_prot && boot_status_byte[BIT_DIS_CLEAR_PROT] && !from_prog |=> !clear_armed)
    else $error("clear command accepted while disabled");
  a_clear_dis_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE17
    $fell(boot_status_byte[BIT_DIS_CLEAR_PROT]) |-> $past(clr_drop))
    else $error("clear-disable bit dropped without programmer clear");

  c_violation: cover property (@(posedge sys_clk) cmd_rsp.violation);
  c_global:    cover property (@(posedge sys_clk) cmd_rsp.array_erase && is_global);
  c_unlock:    cover property (@(posedge sys_clk) key_clr_ok);
  c_irq:       cover property (@(posedge sys_clk) irq);

endmodule : flash_sector_guard

// File: test_flash_sector_guard.sv
// Self-checking bench for the flash sector guard
`timescale 1ns/1ps
module test_flash_sector_guard;
  import flash_guard_pkg::*;
  logic sys_clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, cmd_valid = 0, cmd_chk = 0;
  logic key_write = 0, table_read = 0, rd_d = 0, tr_d = 0, boot_select, write_enable, irq;
  logic [7:0] reg_addr = 0, reg_wdata = 0, key_data = 0, reg_rdata, table_raw, table_data;
  logic [7:0] osc_config;
  logic clk_en = 1'b1;
  logic [15:0] table_addr = 0, boot_address;
  flash_req_t cmd_req = '0;
  flash_rsp_t cmd_rsp;
  logic [7:0] notes[$];
  int mismatches = 0, check_count = 0, i;
  logic [31:0] seed = 32'hcffba27a;
  flash_sector_guard flash_sector_guard_i (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_req(cmd_req), .key_write(key_write),
    .key_data(key_data), .cmd_rsp(cmd_rsp), .table_read(table_read), .table_addr(table_addr),
    .table_raw(table_raw), .table_data(table_data), .boot_address(boot_address),
    .boot_select(boot_select), .write_enable(write_enable), .osc_config(osc_config), .irq(irq));
  flash_array_model flash_array_model_i (.table_read(table_read), .table_addr(table_addr),
    .table_raw(table_raw));
  // ==========================================================================
  // Clock, watchdog, helpers
  // ==========================================================================
  initial forever #4 sys_clk = ~sys_clk;
  // Whole run is under two hundred cycles; this is far beyond it
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    notes.push_back(e);
    @(posedge sys_clk);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Result note holds done, violation, array write, array erase in bits 3:0
  task automatic cmd(input flash_cmd_t c, input prog_source_t s, input logic [2:0] sec,
                     input logic chk, input logic [2:0] e);
    seed = lfsr(seed);
    if (chk) notes.push_back({5'h01, e});
    @(posedge sys_clk);
    cmd_req <= {c, s, sec, seed[12:0], seed[20:13]}; cmd_valid <= 1'b1; cmd_chk <= chk;
    @(posedge sys_clk);
    cmd_valid <= 1'b0; cmd_chk <= 1'b0;
  endtask
  task automatic key(input logic [7:0] d);
    @(posedge sys_clk);
    key_write <= 1'b1; key_data <= d;
    @(posedge sys_clk);
    key_write <= 1'b0;
  endtask
  task automatic tbl(input logic [2:0] sec, input logic prot);
    logic [15:0] a;
    seed = lfsr(seed);
    a = {sec, seed[12:0]};
    notes.push_back(prot ? 8'hff : (a[7:0] ^ a[15:8]));
    @(posedge sys_clk);
    table_addr <= a; table_read <= 1'b1;
    @(posedge sys_clk);
    table_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Monitor: oldest note against whichever result shows this cycle
  // ==========================================================================
  always @(posedge sys_clk) begin
    rd_d <= reg_read;
    tr_d <= table_read;
  end
  always @(negedge sys_clk) begin
    if (rd_d) cmp({8'h00, reg_rdata}, {8'h00, notes.pop_front()});
    if (tr_d) cmp({8'h00, table_data}, {8'h00, notes.pop_front()});
    if (cmd_valid && cmd_chk) cmp({12'h000, cmd_rsp}, {8'h00, notes.pop_front()});
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 8; i++) rd(i[7:0], 8'h00);
    rd(OFFS_BOOT_VECTOR, 8'h1f); rd(OFFS_BOOT_STATUS, 8'h01);
    #1 cmp({8'h00, osc_config}, 16'h0063);
    cmp(boot_address, 16'h1f00);
    cmp({15'h0000, boot_select}, 16'h0001);
    cmp({15'h0000, write_enable}, 16'h0001);
    wr(8'h03, 8'h09); rd(8'h03, 8'h01);
    for (i = 0; i < 4; i++) begin
      tbl(3'd3, 1'b1);
      tbl(3'd2, 1'b0);
    end
    cmd(CMD_SECTOR_CRC, SRC_IN_APPLICATION, 3'd3, 1, 3'b100);
    cmd(CMD_GLOBAL_CRC, SRC_IN_APPLICATION, 3'd0, 1, 3'b100);
    cmd(CMD_PROGRAM, SRC_IN_APPLICATION, 3'd3, 1, 3'b010);
    cmd(CMD_ERASE_SECTOR, SRC_IN_SYSTEM, 3'd3, 1, 3'b001);
    rd(8'h03, 8'h00);
    wr(8'h04, 8'h03); cmd(CMD_SECTOR_CRC, SRC_IN_SYSTEM, 3'd4, 1, 3'b000);
    cmd(CMD_PROGRAM, SRC_IN_SYSTEM, 3'd4, 1, 3'b100);
    cmd(CMD_ERASE_PAGE, SRC_IN_SYSTEM, 3'd4, 1, 3'b100);
    cmd(CMD_ERASE_SECTOR, SRC_IN_APPLICATION, 3'd4, 1, 3'b001);
    rd(8'h04, 8'h00); wr(8'h05, 8'h04);
    cmd(CMD_PROGRAM, SRC_IN_CIRCUIT, 3'd5, 1, 3'b100);
    cmd(CMD_ERASE_PAGE, SRC_IN_CIRCUIT, 3'd5, 1, 3'b100);
    cmd(CMD_ERASE_SECTOR, SRC_IN_APPLICATION, 3'd5, 1, 3'b100);
    cmd(CMD_ERASE_GLOBAL, SRC_IN_SYSTEM, 3'd5, 1, 3'b100);
    cmd(CMD_ERASE_GLOBAL, SRC_PARALLEL, 3'd5, 1, 3'b001);
    rd(8'h05, 8'h00);
    wr(OFFS_IRQ_MASK, 8'h00);
    #1 cmp({15'h0000, irq}, 16'h0000);
    wr(OFFS_IRQ_MASK, 8'h01);
    #1 cmp({15'h0000, irq}, 16'h0001);
    wr(OFFS_IRQ_STATUS, 8'h03);
    #1 cmp({15'h0000, irq}, 16'h0000);
    rd(OFFS_IRQ_STATUS, 8'h00);
    wr(OFFS_BOOT_VECTOR, 8'h05);
    #1 cmp(boot_address, 16'h0500);
    wr(OFFS_BOOT_STATUS, 8'h20);
    #1 cmp({15'h0000, boot_select}, 16'h0000);
    cmd(CMD_CLEAR_WRITE_ENABLE, SRC_IN_APPLICATION, 3'd0, 0, 3'b000);
    #1 cmp({15'h0000, write_enable}, 16'h0000);
    cmd(CMD_PROGRAM, SRC_IN_APPLICATION, 3'd0, 1, 3'b000);
    cmd(CMD_SET_WRITE_ENABLE, SRC_IN_APPLICATION, 3'd0, 0, 3'b000);
    #1 cmp({15'h0000, write_enable}, 16'h0001);
    wr(OFFS_BOOT_STATUS, 8'h61); wr(OFFS_BOOT_VECTOR, 8'h0a); wr(OFFS_OSC_CONFIG, 8'h00);
    rd(OFFS_BOOT_VECTOR, 8'h05); rd(OFFS_OSC_CONFIG, 8'h63);
    cmd(CMD_CLEAR_CONFIG_PROT, SRC_IN_SYSTEM, 3'd0, 0, 3'b000); key(CLEAR_PROT_KEY);
    rd(OFFS_BOOT_STATUS, 8'h21); wr(OFFS_BOOT_STATUS, 8'he1);
    cmd(CMD_WRITE_CONFIG, SRC_IN_APPLICATION, 3'd0, 1, 3'b100);
    cmd(CMD_CLEAR_CONFIG_PROT, SRC_IN_APPLICATION, 3'd0, 0, 3'b000); key(CLEAR_PROT_KEY);
    rd(OFFS_BOOT_STATUS, 8'he1);
    cmd(CMD_CLEAR_CONFIG_PROT, SRC_IN_CIRCUIT, 3'd0, 0, 3'b000); key(CLEAR_PROT_KEY);
    rd(OFFS_BOOT_STATUS, 8'h21);
    wr(OFFS_BOOT_STATUS, 8'ha1); wr(OFFS_BOOT_STATUS, 8'h21);
    rd(OFFS_BOOT_STATUS, 8'ha1);
    // A write while the clock enable is low must leave the sector byte alone
    @(posedge sys_clk) clk_en <= 1'b0;
    wr(8'h06, 8'h07);
    @(posedge sys_clk) clk_en <= 1'b1;
    rd(8'h06, 8'h00);
    rd(8'h20, 8'h00);
    repeat (2) @(posedge sys_clk);
    final_report();
  end
endmodule // test_flash_sector_guard
